// >>> nio_ports.sv
`timescale 1ns/1ps
`default_nettype none
`include "nio_defs.svh"
module nio_ports
  import nio_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [3:0] primary_bidir_port_in_i,
  output logic [3:0] primary_bidir_port_out_o,
  output logic [3:0] primary_bidir_port_oe_o,
  output logic [3:0] primary_bidir_port_pu_o,
  input wire logic [3:0] second_bidir_port_in_i,
  output logic [3:0] second_bidir_port_out_o,
  output logic [3:0] second_bidir_port_oe_o,
  output logic [3:0] second_bidir_port_pu_o,
  input wire logic [3:0] third_bidir_port_in_i,
  output logic [3:0] third_bidir_port_out_o,
  output logic [3:0] third_bidir_port_oe_o,
  output logic [3:0] third_bidir_port_pu_o,
  input wire logic [2:0] narrow_bidir_port_in_i,
  output logic [2:0] narrow_bidir_port_out_o,
  output logic [2:0] narrow_bidir_port_oe_o,
  output logic [2:0] narrow_bidir_port_pu_o,
  input wire logic [3:0] input_only_port_i,
  output logic [3:0] input_only_port_pu_o,
  output logic [7:0] output_only_port_o,
  input wire logic sio_clk_i,
  input wire logic sio_clk_oe_i,
  input wire logic sio_dout_i,
  output logic sio_din_o,
  output logic [6:0] irq_req_o
);

  localparam int PRE_CYC = `NIO_CLK_HZ / (2 * `NIO_BUZ_MAX_HZ);
  localparam logic [`NIO_PRE_W-1:0] PRE_LAST = `NIO_PRE_W'(PRE_CYC - 1);

  nio_state_s st_q;
  nio_state_s st_d;
  nio_sync_if sy ();

  logic [3:0][3:0] pin;
  logic [3:0][3:0] view;
  logic [3:0][3:0] mask;
  logic [3:0] in_pins;
  logic [7:0] ev;
  logic [7:0] clr;
  logic [31:0] rd;
  logic err;
  logic wr;
  logic setup;
  logic tick;
  logic buzzer_tone_out;
  logic [2:0] pn;
  logic [2:0] bn;
  logic [1:0] k;
  logic [3:0] val;
  logic [3:0] en;

  assign sy.raw = {narrow_bidir_port_in_i, third_bidir_port_in_i, second_bidir_port_in_i,
                   input_only_port_i, primary_bidir_port_in_i};

  nio_pin_sync u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sy(sy)
  );

  always_comb begin
    st_d = st_q;
    pin[0] = sy.lvl[3:0];
    pin[1] = sy.lvl[11:8];
    pin[2] = sy.lvl[15:12];
    pin[3] = {1'b0, sy.lvl[18:16]};
    in_pins = sy.lvl[7:4];
    mask = {`NIO_NARROW_MASK, 4'hf, 4'hf, 4'hf};
    for (int i = 0; i < 4; i++) begin
      view[i] = (st_q.dir[i] & st_q.lat[i]) | (~st_q.dir[i] & pin[i]);
    end

    // buzzer: 32 kHz enable, counter bits give 16/8/4/2 kHz
    tick = (st_q.pre == PRE_LAST);
    st_d.pre = tick ? '0 : st_q.pre + 1'b1;
    if (tick) begin
      st_d.buz_cnt = st_q.buz_cnt + 4'h1;
    end
    buzzer_tone_out = st_q.buz_cnt[2'h3 - st_q.alt[`NIO_ALT_RATE_LO +: 2]];

    // edge events from synchronised pins
    ev[3:0] = (st_q.pol[3:0] & sy.rise[3:0]) | (~st_q.pol[3:0] & sy.fall[3:0]);
    ev[4] = st_q.pol[4] ? sy.rise[4] : sy.fall[4];
    ev[5] = st_q.pol[5] ? sy.rise[5] : sy.fall[5];
    ev[6] = st_q.pol[6] ? sy.rise[6] : sy.fall[6];
    ev[7] = sy.rise[7] | sy.fall[7];

    // apb: setup cycle registers answer, access edge commits write
    setup = psel_i & ~penable_i;
    wr = psel_i & penable_i & st_q.pready & pwrite_i;
    st_d.pready = setup;
    rd = '0;
    err = 1'b0;
    clr = '0;
    pn = paddr_i[7:5];
    bn = paddr_i[4:2];
    k = (pn == 3'h0) ? 2'h0 : 2'(pn - 3'h1);
    if (paddr_i[11:6] == 6'h0 && paddr_i[3:2] != 2'h3) begin
      if (paddr_i[3:2] == `NIO_A_DATA) begin
        rd[3:0] = view[paddr_i[5:4]];
        if (wr) begin
          st_d.lat[paddr_i[5:4]] = pwdata_i[3:0] & mask[paddr_i[5:4]];
        end
      end else if (paddr_i[3:2] == `NIO_A_DIR) begin
        rd[3:0] = st_q.dir[paddr_i[5:4]];
        if (wr) begin
          st_d.dir[paddr_i[5:4]] = pwdata_i[3:0] & mask[paddr_i[5:4]];
        end
      end else begin
        rd[3:0] = st_q.od[paddr_i[5:4]];
        if (wr) begin
          st_d.od[paddr_i[5:4]] = pwdata_i[3:0] & mask[paddr_i[5:4]];
        end
      end
    end else if (paddr_i == `NIO_A_IN_DATA) begin
      rd[3:0] = in_pins;
    end else if (paddr_i == `NIO_A_IN_PU) begin
      rd[3:0] = st_q.in_pu;
      if (wr) begin
        st_d.in_pu = pwdata_i[3:0];
      end
    end else if (paddr_i == `NIO_A_OUT_PORT) begin
      rd[7:0] = st_q.out_port;
      if (wr) begin
        st_d.out_port = pwdata_i[7:0];
      end
    end else if (paddr_i == `NIO_A_PU_GRP) begin
      rd[3:0] = st_q.pu_grp;
      if (wr) begin
        st_d.pu_grp = pwdata_i[3:0];
      end
    end else if (paddr_i == `NIO_A_WIDE) begin
      rd[7:0] = {view[2], view[1]};
      if (wr) begin
        st_d.lat[1] = pwdata_i[3:0];
        st_d.lat[2] = pwdata_i[7:4];
      end
    end else if (paddr_i == `NIO_A_ALT) begin
      rd[3:0] = st_q.alt;
      if (wr) begin
        st_d.alt = pwdata_i[3:0];
      end
    end else if (paddr_i == `NIO_A_EDGE) begin
      rd[6:0] = st_q.pol;
      if (wr) begin
        st_d.pol = pwdata_i[6:0];
      end
    end else if (paddr_i == `NIO_A_PEND) begin
      rd[7:0] = st_q.pend;
      if (wr) begin
        clr = pwdata_i[7:0];
      end
    end else if (paddr_i[11:8] == `NIO_A_BIT_PAGE) begin
      if (pn == 3'h1) begin
        err = bn[2];
        rd[0] = in_pins[bn[1:0]];
      end else if (pn == 3'h5) begin
        rd[0] = st_q.out_port[bn];
        if (wr) begin
          st_d.out_port[bn] = pwdata_i[0];
        end
      end else if (pn < 3'h5) begin
        err = bn[2] | ~mask[k][bn[1:0]];
        rd[0] = view[k][bn[1:0]];
        if (wr && !err) begin
          st_d.lat[k][bn[1:0]] = pwdata_i[0];
        end
      end else begin
        err = 1'b1;
      end
    end else begin
      err = 1'b1;
    end
    st_d.prdata = setup ? rd : '0;
    st_d.pslverr = setup & err;
    st_d.pend = (st_q.pend & ~clr) | ev;

    // pin drivers, alternate functions on the primary port
    for (int i = 0; i < 4; i++) begin
      val = st_q.lat[i];
      en = st_q.dir[i];
      if (i == 0 && st_q.alt[`NIO_ALT_SIO]) begin
        val[1:0] = {sio_dout_i, sio_clk_i};
        en[2:0] = {1'b0, 1'b1, sio_clk_oe_i};
      end
      if (i == 0 && st_q.alt[`NIO_ALT_BUZ]) begin
        val[3] = buzzer_tone_out;
        en[3] = 1'b1;
      end
      st_d.pin_out[i] = val & mask[i];
      st_d.pin_oe[i] = en & (~st_q.od[i] | ~val) & mask[i];
      // pull-up off on any pin set as output, even when an alternate function releases it
      st_d.pin_pu[i] = {4{st_q.pu_grp[i]}} & ~(en | st_q.dir[i]) & mask[i];
    end
    st_d.sio_din = pin[0][2];
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_q <= '0;
      st_q.out_port <= `NIO_RST_OUT_PORT;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata_o = st_q.prdata;
  assign pready_o = st_q.pready;
  assign pslverr_o = st_q.pslverr;
  assign primary_bidir_port_out_o = st_q.pin_out[0];
  assign primary_bidir_port_oe_o = st_q.pin_oe[0];
  assign primary_bidir_port_pu_o = st_q.pin_pu[0];
  assign second_bidir_port_out_o = st_q.pin_out[1];
  assign second_bidir_port_oe_o = st_q.pin_oe[1];
  assign second_bidir_port_pu_o = st_q.pin_pu[1];
  assign third_bidir_port_out_o = st_q.pin_out[2];
  assign third_bidir_port_oe_o = st_q.pin_oe[2];
  assign third_bidir_port_pu_o = st_q.pin_pu[2];
  assign narrow_bidir_port_out_o = st_q.pin_out[3][2:0];
  assign narrow_bidir_port_oe_o = st_q.pin_oe[3][2:0];
  assign narrow_bidir_port_pu_o = st_q.pin_pu[3][2:0];
  assign input_only_port_pu_o = st_q.in_pu;
  assign output_only_port_o = st_q.out_port;
  assign sio_din_o = st_q.sio_din;
  assign irq_req_o = {st_q.pend[`NIO_EV_BOTH], st_q.pend[5:0]};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_apb_wr(logic [11:0] a);
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == a;
  endsequence

  a_pu_off_out: assert property (1 |=> (primary_bidir_port_pu_o & $past(st_q.dir[0])) == 4'h0)
    else $error("pull-up left on an output pin");
  a_od_no_high: assert property (!$past(st_q.alt[`NIO_ALT_BUZ]) |=>
    (second_bidir_port_oe_o & second_bidir_port_out_o & $past(st_q.od[1])) == 4'h0)
    else $error("open-drain pin driven high");
  a_input_no_drive: assert property (1 |=> (third_bidir_port_oe_o & ~$past(st_q.dir[2])) == 4'h0)
    else $error("input pin is driven");
  a_narrow_three: assert property (st_q.dir[3][3] == 1'b0 && st_q.pin_oe[3][3] == 1'b0)
    else $error("narrow port fourth pin active");
  a_quasi_sets: assert property (sy.rise[6] && st_q.pol[6] |=> st_q.pend[`NIO_EV_QUASI])
    else $error("quasi edge not recorded");
  a_both_edges: assert property ((sy.rise[7] || sy.fall[7]) ##1 1'b1 |-> irq_req_o[6])
    else $error("both-edge input missed an edge");
  a_ext_edge: assert property (sy.fall[4] && !st_q.pol[4] |=> irq_req_o[4])
    else $error("external edge not flagged");
  a_key_edge: assert property (sy.rise[0] && st_q.pol[0] |=> irq_req_o[0])
    else $error("key edge not flagged");
  a_out_write: assert property (s_apb_wr(`NIO_A_OUT_PORT) |=> output_only_port_o == $past(pwdata_i[7:0]))
    else $error("output port write lost");
  a_dir_write: assert property (s_apb_wr(12'h004) |=> st_q.dir[0] == $past(pwdata_i[3:0]))
    else $error("direction write lost");
  a_buz_steady: assert property (st_q.pre != PRE_LAST |=> $stable(st_q.buz_cnt))
    else $error("buzzer counter moved off tick");

endmodule
`default_nettype wire

// >>> nio_defs.svh
`ifndef NIO_DEFS_SVH
`define NIO_DEFS_SVH

// bidir ports: index 0 primary, 1 second, 2 third, 3 narrow
// port data at idx*0x10, direction +0x4, open-drain +0x8
`define NIO_A_DATA 2'h0
`define NIO_A_DIR 2'h1
`define NIO_A_OD 2'h2
`define NIO_A_IN_DATA 12'h040
`define NIO_A_IN_PU 12'h044
`define NIO_A_OUT_PORT 12'h048
`define NIO_A_PU_GRP 12'h04c
`define NIO_A_WIDE 12'h050
`define NIO_A_ALT 12'h054
`define NIO_A_EDGE 12'h058
`define NIO_A_PEND 12'h05c
`define NIO_A_BIT_PAGE 4'h1

// alternate function register fields
`define NIO_ALT_SIO 0
`define NIO_ALT_BUZ 1
`define NIO_ALT_RATE_LO 2

// pending flag positions
`define NIO_EV_EXT_A 4
`define NIO_EV_EXT_B 5
`define NIO_EV_QUASI 6
`define NIO_EV_BOTH 7

`define NIO_RST_OUT_PORT 8'hff
`define NIO_NARROW_MASK 4'h7

`define NIO_CLK_HZ 40000000
`define NIO_BUZ_MAX_HZ 16000
`define NIO_PRE_W 11
`define NIO_SYNC_W 19

`endif

// >>> nio_pkg.sv
package nio_pkg;

  typedef logic [3:0][3:0] nio_nib4_t;

  typedef struct packed {
    nio_nib4_t lat;
    nio_nib4_t dir;
    nio_nib4_t od;
    nio_nib4_t pin_out;
    nio_nib4_t pin_oe;
    nio_nib4_t pin_pu;
    logic [3:0] pu_grp;
    logic [3:0] in_pu;
    logic [7:0] out_port;
    logic [3:0] alt;
    logic [6:0] pol;
    logic [7:0] pend;
    logic [10:0] pre;
    logic [3:0] buz_cnt;
    logic sio_din;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } nio_state_s;

  typedef struct packed {
    logic [18:0] s1;
    logic [18:0] s2;
    logic [18:0] s3;
    logic [1:0] fill;
  } nio_sync_s;

endpackage

// >>> nio_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nio_sync_if;
  logic [18:0] raw;
  logic [18:0] lvl;
  logic [18:0] rise;
  logic [18:0] fall;
  modport sync (input raw, output lvl, output rise, output fall);
  modport user (output raw, input lvl, input rise, input fall);
endinterface
`default_nettype wire

// >>> nio_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module nio_pin_sync
  import nio_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  nio_sync_if.sync sy
);

  nio_sync_s st_q;
  nio_sync_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = sy.raw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.fill != 2'h3) begin
      st_d.fill = st_q.fill + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // edges only once the chain holds real samples
  assign sy.lvl = st_q.s2;
  assign sy.rise = (st_q.fill == 2'h3) ? (st_q.s2 & ~st_q.s3) : '0;
  assign sy.fall = (st_q.fill == 2'h3) ? (~st_q.s2 & st_q.s3) : '0;

endmodule
`default_nettype wire

// >>> nio_board.sv
`timescale 1ns/1ps
`default_nettype none
module nio_board (
  input wire logic [3:0] out_i,
  input wire logic [3:0] oe_i,
  input wire logic [3:0] ext_i,
  output logic [3:0] pin_o
);
  // device drive wins, otherwise the board level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_o[i] = oe_i[i] ? out_i[i] : ext_i[i];
    end
  end
endmodule
`default_nettype wire

// >>> tb_nibble_io_ports_with_edge_irq.sv
`timescale 1ns/1ps
`default_nettype none
module tb_nibble_io_ports_with_edge_irq import nio_pkg::*;;
  logic clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwr = 0, perr, sdin, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] out_a[4], oe_a[4], pu_a[4], pin_a[4];
  logic [3:0] ext_a[4] = '{default:0};
  logic [3:0] in_pins = 0, in_pu;
  logic [7:0] oport;
  logic [6:0] irq;
  logic sclk = 0, scoe = 0, sdout = 0;
  int fails = 0, samples_checked = 0;
  initial forever #12.5 clk_i = ~clk_i;
  for (genvar g = 0; g < 4; g++) begin : brd
    nio_board u_b (.out_i(out_a[g]), .oe_i(oe_a[g]), .ext_i(ext_a[g]), .pin_o(pin_a[g]));
  end
  nio_ports dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .primary_bidir_port_in_i(pin_a[0]), .primary_bidir_port_out_o(out_a[0]),
    .primary_bidir_port_oe_o(oe_a[0]), .primary_bidir_port_pu_o(pu_a[0]),
    .second_bidir_port_in_i(pin_a[1]), .second_bidir_port_out_o(out_a[1]),
    .second_bidir_port_oe_o(oe_a[1]), .second_bidir_port_pu_o(pu_a[1]),
    .third_bidir_port_in_i(pin_a[2]), .third_bidir_port_out_o(out_a[2]),
    .third_bidir_port_oe_o(oe_a[2]), .third_bidir_port_pu_o(pu_a[2]),
    .narrow_bidir_port_in_i(pin_a[3][2:0]), .narrow_bidir_port_out_o(out_a[3][2:0]),
    .narrow_bidir_port_oe_o(oe_a[3][2:0]), .narrow_bidir_port_pu_o(pu_a[3][2:0]),
    .input_only_port_i(in_pins), .input_only_port_pu_o(in_pu), .output_only_port_o(oport),
    .sio_clk_i(sclk), .sio_clk_oe_i(scoe), .sio_dout_i(sdout), .sio_din_o(sdin), .irq_req_o(irq));
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic setsrc(input int j, input logic v);
    if (j < 4) ext_a[0][j] <= v;
    else in_pins[j-4] <= v;
  endtask
  initial begin
    logic [31:0] r, v;
    logic [3:0] d, o, l, m;
    logic e, p, k;
    int t;
    r = $urandom(62);
    cyc(12);
    reset_i <= 1'b0;
    cyc(1);
    chk("oport", oport, 32'h0ff);
    for (int i = 0; i < 4; i++) for (int c = 0; c < 3; c++) begin
      m = (i == 3) ? 4'h7 : 4'hf;
      d = 4'($urandom); o = 4'($urandom); l = 4'($urandom) & m; p = 1'($urandom); ext_a[i] <= 4'($urandom);
      wr(12'(i*16+4), d); wr(12'(i*16+8), o); wr(12'(i*16), l); wr(12'h04c, 32'(p) << i);
      cyc(4);
      chk("oe", oe_a[i] & m, d & ~(o & l) & m);
      chk("out", out_a[i] & d & ~o & m, l & d & ~o & m);
      chk("pu", pu_a[i] & m, {4{p}} & ~d & m);
      apb(1'b0, 12'(i*16), 0, r);
      chk("data", r, ((l & d) | (ext_a[i] & ~d)) & m);
    end
    wr(12'h014, 32'hf); wr(12'h024, 32'hf); v = $urandom & 32'hff; wr(12'h050, v);
    apb(1'b0, 12'h050, 0, r);
    chk("wide", r, v);
    apb(1'b0, 12'h010, 0, r);
    chk("wide_lo", r, v & 32'hf);
    in_pins <= 4'($urandom); d = 4'($urandom); wr(12'h044, d); wr(12'h040, 32'hf); cyc(4);
    apb(1'b0, 12'h040, 0, r);
    chk("in_port", r, in_pins);
    chk("in_pu", in_pu, d);
    t = $urandom % 4;
    apb(1'b0, 12'(12'h120 + t*4), 0, r);
    chk("in_bit", r, in_pins[t]);
    apb(1'b0, 12'hffc, 0, r);
    chk("unmapped", perr, 1);
    v = $urandom & 32'hff; wr(12'h048, v); cyc(2);
    chk("oport_w", oport, v);
    wr(12'h004, 32'hf); wr(12'h008, 0); l = 0;
    for (int b = 0; b < 8; b++) begin
      e = 1'($urandom); v[b] = e; wr(12'(12'h1a0 + b*4), e);
      if (b < 4) begin
        l[b] = e; wr(12'(12'h100 + b*4), e);
      end
    end
    cyc(2);
    chk("oport_bits", oport, v & 32'hff);
    chk("prim_bits", out_a[0], l);
    wr(12'h034, 32'h7); l = 0;
    for (int b = 0; b < 3; b++) begin
      e = 1'($urandom); l[b] = e; wr(12'(12'h180 + b*4), e);
    end
    apb(1'b0, 12'h030, 0, r);
    chk("narrow_bits", r, l);
    apb(1'b0, 12'h18c, 0, r);
    chk("narrow_bit3", perr, 1);
    wr(12'h004, 0);
    for (int j = 0; j < 8; j++) for (int e2 = 0; e2 < 2; e2++) begin
      p = 1'($urandom); wr(12'h058, 32'(p) << j);
      setsrc(j, !e2); cyc(8); wr(12'h05c, 32'hff);
      setsrc(j, e2); cyc(8);
      apb(1'b0, 12'h05c, 0, r);
      k = (j == 7) || (p == e2);
      chk("pend", r[j], k);
      chk("irq", irq, (j == 6) ? 0 : 32'(k) << ((j == 7) ? 6 : j));
      if (j == 2) chk("sio_din", sdin, e2);
      wr(12'h05c, 32'hff);
    end
    wr(12'h04c, 32'h1); wr(12'h054, 32'h1);
    for (int c = 0; c < 4; c++) begin
      sclk <= 1'($urandom); scoe <= 1'($urandom); sdout <= 1'($urandom);
      cyc(2);
      chk("sio_out", out_a[0][1:0], {sdout, sclk});
      chk("sio_oe", oe_a[0], {2'b00, 1'b1, scoe});
      chk("sio_pu", pu_a[0], {2'b11, 1'b0, ~scoe});
    end
    wr(12'h004, 32'h8);
    for (int q = 0; q < 4; q++) begin
      wr(12'h054, 32'((q << 2) | 2)); t = 0; e = out_a[0][3];
      for (int c = 0; c < 10000; c++) begin
        @(posedge clk_i);
        if (out_a[0][3] !== e) t++;
        e = out_a[0][3];
      end
      chk("buz", (t >= (1 << q) - 1) && (t <= (1 << q) + 1), 1);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
